// [pkg/chonoff_defs.svh]
// chonoff_defs.svh: global page, channel count, field positions, reset values and timing counts
// for the channel on/off and margin control block.
// assumes a 100 MHz ref_clk; included by bare name.
`ifndef CHONOFF_DEFS_SVH
`define CHONOFF_DEFS_SVH

// page selector value that reaches every channel
`define CHO_GLOBAL_PAGE   8'hff
`define CHO_NUM_CHAN      8

// power command byte fields
`define CHO_OP_CTL_HI     7
`define CHO_OP_CTL_LO     6
`define CHO_OP_MRG_HI     5
`define CHO_OP_MRG_LO     4
`define CHO_OP_FLT_HI     3
`define CHO_OP_FLT_LO     2

// switch config byte fields
`define CHO_CFG_CTRL_ON   4
`define CHO_CFG_USE_BUS   3
`define CHO_CFG_USE_PIN   2
`define CHO_CFG_FAST_OFF  0

// reset values
`define CHO_OP_RST        8'h80
`define CHO_CFG_RST       8'h1e

// timing
`define CHO_CLK_MHZ       100
`define CHO_T_INIT_US     100
`define CHO_T_INIT_CYC    (`CHO_T_INIT_US * `CHO_CLK_MHZ)

`endif

// [pkg/chonoff_pkg.sv]
// chonoff_pkg: types shared by the on/off control top and its channel fsm.
// assumes chonoff_defs.svh holds the numeric constants.
package chonoff_pkg;

    typedef enum logic {
        CHO_CMD_POWER,
        CHO_CMD_SWITCH
    } cho_cmd_t;

    typedef struct packed {
        logic [7:0] page;
        cho_cmd_t   sel;
        logic [7:0] data;
    } cho_wr_t;

    typedef enum logic [1:0] {
        CHO_ST_OFF,
        CHO_ST_TON,
        CHO_ST_ON,
        CHO_ST_TOFF
    } cho_state_t;

endpackage : chonoff_pkg

// [src/chonoff_chan.sv]
// chonoff_chan: one channel's on/off sequencer with share-clock delays.
// assumes want_on, imm_off and share_tick are on ref_clk already.
`timescale 1ns/10ps
`default_nettype none
module chonoff_chan (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // control
    input  wire logic        start_ok,
    input  wire logic        want_on,
    input  wire logic        imm_off,
    input  wire logic        share_tick,
    // delays in share-clock ticks
    input  wire logic [15:0] ton_delay,
    input  wire logic [15:0] toff_delay,
    // status
    output logic             enable_q,
    output logic             seq_off_q
);

    chonoff_pkg::cho_state_t state_q, state_d;
    logic [15:0]             cnt_q, cnt_d;
    logic                    enable_d;

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        case (state_q)
            chonoff_pkg::CHO_ST_OFF: begin
                if (want_on && start_ok) begin
                    state_d = chonoff_pkg::CHO_ST_TON;
                    cnt_d   = ton_delay;
                end
            end
            chonoff_pkg::CHO_ST_TON: begin
                if (!want_on) begin
                    state_d = chonoff_pkg::CHO_ST_OFF;
                end else if (cnt_q == 16'h0000) begin
                    state_d = chonoff_pkg::CHO_ST_ON;
                end else if (share_tick) begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            chonoff_pkg::CHO_ST_ON: begin
                if (!want_on) begin
                    state_d = imm_off ? chonoff_pkg::CHO_ST_OFF
                                      : chonoff_pkg::CHO_ST_TOFF;
                    cnt_d   = toff_delay;
                end
            end
            chonoff_pkg::CHO_ST_TOFF: begin
                // immediate off overrides a running off delay
                if (imm_off || cnt_q == 16'h0000) begin
                    state_d = chonoff_pkg::CHO_ST_OFF;
                end else if (share_tick) begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            default: begin
                state_d = chonoff_pkg::CHO_ST_OFF;
            end
        endcase
        enable_d = (state_d == chonoff_pkg::CHO_ST_ON) ||
                   (state_d == chonoff_pkg::CHO_ST_TOFF);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q   <= chonoff_pkg::CHO_ST_OFF;
            cnt_q     <= 16'h0000;
            enable_q  <= 1'b0;
            seq_off_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            enable_q  <= enable_d;
            seq_off_q <= (state_d == chonoff_pkg::CHO_ST_TOFF);
        end
    end

endmodule : chonoff_chan
`default_nettype wire

// [src/chonoff_top.sv]
// chonoff_top: per-channel on/off and margin control for eight supplies.
// assumes a command decoder upstream delivers byte writes and reads of the
// power command and switch config registers with their page selector.
`timescale 1ns/10ps
`default_nettype none
`include "chonoff_defs.svh"

module chonoff_top #(
    parameter int NUM_CHAN    = `CHO_NUM_CHAN,
    parameter int T_INIT_CYC  = `CHO_T_INIT_CYC
) (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       reset,
    // register writes
    input  wire logic                       cmd_wr_stb,
    input  wire chonoff_pkg::cho_wr_t       cmd_wr,
    // register reads
    input  wire logic                       cmd_rd_stb,
    input  wire chonoff_pkg::cho_cmd_t      cmd_rd_sel,
    input  wire logic [7:0]                 cmd_rd_page,
    output logic [7:0]                      rd_data,
    output logic                            rd_valid,
    output logic                            wr_reject,
    // pins, asynchronous
    input  wire logic [NUM_CHAN-1:0]        run_pin,
    input  wire logic                       input_voltage_sense,
    input  wire logic                       share_clk,
    // delays in share-clock ticks
    input  wire logic [NUM_CHAN-1:0][15:0]  ton_delay,
    input  wire logic [NUM_CHAN-1:0][15:0]  toff_delay,
    // channel outputs
    output logic [NUM_CHAN-1:0]             converter_enable_out,
    output logic [NUM_CHAN-1:0][1:0]        margin_sel,
    output logic [NUM_CHAN-1:0]             ignore_faults,
    output logic [NUM_CHAN-1:0]             seq_off_busy,
    output logic                            init_done
);

    localparam int NPIN = NUM_CHAN + 2;

    // valid power command byte for a given bus-control setting
    function automatic logic op_valid(input logic [7:0] b,
                                      input logic       use_bus);
        logic [1:0] ctl;
        logic [1:0] mrg;
        logic [1:0] flt;
        ctl = b[`CHO_OP_CTL_HI:`CHO_OP_CTL_LO];
        mrg = b[`CHO_OP_MRG_HI:`CHO_OP_MRG_LO];
        flt = b[`CHO_OP_FLT_HI:`CHO_OP_FLT_LO];
        op_valid = (use_bus && ctl == 2'h0) ||
                   (ctl != 2'h3 &&
                    (mrg == 2'h0 ||
                     (mrg != 2'h3 && (flt == 2'h1 || flt == 2'h2))));
    endfunction : op_valid

    // page decode: channel hit
    function automatic logic page_hit(input logic [7:0] page,
                                      input int         ch);
        page_hit = (page == `CHO_GLOBAL_PAGE) || (page == 8'(ch));
    endfunction : page_hit

    // pin synchronisers: three stages, a change counts once 2 and 3 agree
    logic [NPIN-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_st_q;
    logic [NPIN-1:0] pin_st_d;
    logic            share_tick_d, share_tick_q;

    always_comb begin
        pin_st_d     = pin_st_q;
        for (int i = 0; i < NPIN; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
                pin_st_d[i] = pin_s3_q[i];
            end
        end
        share_tick_d = pin_st_d[NPIN-1] && !pin_st_q[NPIN-1];
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_s1_q     <= '0;
            pin_s2_q     <= '0;
            pin_s3_q     <= '0;
            pin_st_q     <= '0;
            share_tick_q <= 1'b0;
        end else begin
            pin_s1_q     <= {share_clk, input_voltage_sense, run_pin};
            pin_s2_q     <= pin_s1_q;
            pin_s3_q     <= pin_s2_q;
            pin_st_q     <= pin_st_d;
            share_tick_q <= share_tick_d;
        end
    end

    logic [NUM_CHAN-1:0] run_st;
    logic                vin_ok;
    assign run_st = pin_st_q[NUM_CHAN-1:0];
    assign vin_ok = pin_st_q[NUM_CHAN];

    // initialization interval after reset
    logic [31:0] init_cnt_q, init_cnt_d;
    logic        init_done_d;

    always_comb begin
        init_cnt_d  = init_cnt_q;
        if (init_cnt_q < 32'(T_INIT_CYC)) begin
            init_cnt_d = init_cnt_q + 32'h1;
        end
        init_done_d = (init_cnt_d >= 32'(T_INIT_CYC));
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            init_cnt_q <= 32'h0;
            init_done  <= 1'b0;
        end else begin
            init_cnt_q <= init_cnt_d;
            init_done  <= init_done_d;
        end
    end

    // command registers per channel
    logic [NUM_CHAN-1:0][7:0] op_q, op_d;
    logic [NUM_CHAN-1:0][7:0] cfg_q, cfg_d;
    logic                     reject_d;

    always_comb begin
        op_d     = op_q;
        cfg_d    = cfg_q;
        reject_d = 1'b0;
        if (cmd_wr_stb) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                if (page_hit(cmd_wr.page, c)) begin
                    if (cmd_wr.sel == chonoff_pkg::CHO_CMD_SWITCH) begin
                        cfg_d[c] = {3'h0, cmd_wr.data[4:2], 1'b1,
                                    cmd_wr.data[0]};
                    end else if (op_valid(cmd_wr.data,
                                 cfg_q[c][`CHO_CFG_USE_BUS])) begin
                        op_d[c] = {cmd_wr.data[7:2], 2'h0};
                    end else begin
                        reject_d = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                op_q[c]  <= `CHO_OP_RST;
                cfg_q[c] <= `CHO_CFG_RST;
            end
            wr_reject <= 1'b0;
        end else begin
            op_q      <= op_d;
            cfg_q     <= cfg_d;
            wr_reject <= reject_d;
        end
    end

    // read-back; pages outside the channel range return zero
    logic [7:0] rd_data_d;

    always_comb begin
        rd_data_d = 8'h00;
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (cmd_rd_page == 8'(c)) begin
                rd_data_d = (cmd_rd_sel == chonoff_pkg::CHO_CMD_SWITCH) ?
                            cfg_q[c] : op_q[c];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_data  <= cmd_rd_stb ? rd_data_d : rd_data;
            rd_valid <= cmd_rd_stb;
        end
    end

    // per-channel on/off decision and margin outputs
    logic [NUM_CHAN-1:0]      want_on, imm_off, seq_off;
    logic [NUM_CHAN-1:0][1:0] mrg_d;
    logic [NUM_CHAN-1:0]      ign_d;

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            logic [1:0] ctl, mrg, flt;
            logic       ctrl_on, use_bus, use_pin, fast_off;
            logic       pin_ok, bus_ok, bus_imm, pin_imm;

            assign ctl      = op_q[g][`CHO_OP_CTL_HI:`CHO_OP_CTL_LO];
            assign mrg      = op_q[g][`CHO_OP_MRG_HI:`CHO_OP_MRG_LO];
            assign flt      = op_q[g][`CHO_OP_FLT_HI:`CHO_OP_FLT_LO];
            assign ctrl_on  = cfg_q[g][`CHO_CFG_CTRL_ON];
            assign use_bus  = cfg_q[g][`CHO_CFG_USE_BUS];
            assign use_pin  = cfg_q[g][`CHO_CFG_USE_PIN];
            assign fast_off = cfg_q[g][`CHO_CFG_FAST_OFF];

            assign pin_ok  = !use_pin || run_st[g];
            assign bus_ok  = !use_bus || (ctl == 2'h2);
            assign bus_imm = use_bus && (ctl == 2'h0);
            assign pin_imm = use_pin && !run_st[g] && fast_off;

            always_comb begin
                if (!ctrl_on) begin
                    want_on[g] = 1'b1;
                end else if (!use_bus && !use_pin) begin
                    want_on[g] = 1'b0;
                end else begin
                    want_on[g] = pin_ok && bus_ok;
                end
                imm_off[g] = ctrl_on && (bus_imm || pin_imm);
                // margin at nominal on a bus-commanded immediate off or margin code 3
                mrg_d[g] = (bus_imm || mrg == 2'h3) ? 2'h0 : mrg;
                ign_d[g] = (mrg_d[g] != 2'h0) && (flt == 2'h1);
            end

            chonoff_chan u_chan (
                .ref_clk    (ref_clk),
                .reset      (reset),
                .start_ok   (init_done && vin_ok),
                .want_on    (want_on[g]),
                .imm_off    (imm_off[g]),
                .share_tick (share_tick_q),
                .ton_delay  (ton_delay[g]),
                .toff_delay (toff_delay[g]),
                .enable_q   (converter_enable_out[g]),
                .seq_off_q  (seq_off[g])
            );
        end
    endgenerate

    // registered margin, fault-ignore and off-sequence busy outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            margin_sel    <= '0;
            ignore_faults <= '0;
            seq_off_busy  <= '0;
        end else begin
            margin_sel    <= mrg_d;
            ignore_faults <= ign_d;
            seq_off_busy  <= seq_off;
        end
    end

endmodule : chonoff_top
`default_nettype wire

// [testbench/cho_properties.sv]
// cho_properties.sv: port-level assertions for the on/off control top.
// assumes a single ref_clk domain and an active-high synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module cho_checker #(
    parameter int NUM_CHAN   = 8,
    parameter int T_INIT_CYC = 20
) (
    // clock and reset
    input wire logic                     ref_clk,
    input wire logic                     reset,
    // register side
    input wire logic                     cmd_wr_stb,
    input wire chonoff_pkg::cho_wr_t     cmd_wr,
    input wire logic                     cmd_rd_stb,
    input wire logic [7:0]               rd_data,
    input wire logic                     rd_valid,
    input wire logic                     wr_reject,
    // channel side
    input wire logic                     input_voltage_sense,
    input wire logic [NUM_CHAN-1:0]      converter_enable_out,
    input wire logic [NUM_CHAN-1:0][1:0] margin_sel,
    input wire logic [NUM_CHAN-1:0]      ignore_faults,
    input wire logic                     init_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [15:0] cyc_q;
    logic [15:0] cyc_d;
    logic        bad_mrg;
    logic        bad_ign;
    // saturating count of cycles since reset release
    always_comb begin
        cyc_d = (cyc_q == 16'hffff) ? cyc_q : cyc_q + 16'h1;
        if (reset) begin
            cyc_d = 16'h0;
        end
    end
    always_ff @(posedge ref_clk) begin
        cyc_q <= cyc_d;
    end
    always_comb begin
        bad_mrg = 1'b0;
        bad_ign = 1'b0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            bad_mrg = bad_mrg | (margin_sel[i] == 2'b11);
            bad_ign = bad_ign | (ignore_faults[i] & (margin_sel[i] == 2'b00));
        end
    end
    AST_RST_QUIET: assert property ($fell(reset) |->
        converter_enable_out == '0 && !init_done) else $error("busy at reset");
    AST_RD_VALID: assert property (cmd_rd_stb |=> rd_valid)
        else $error("read strobe gave no valid");
    AST_RD_IDLE: assert property (!cmd_rd_stb |=> !rd_valid)
        else $error("valid without read strobe");
    AST_RD_HOLD: assert property (!cmd_rd_stb |=> $stable(rd_data))
        else $error("read data moved without a read");
    AST_INIT_EARLY: assert property (init_done |->
        cyc_q >= 16'(T_INIT_CYC - 1)) else $error("init ended early");
    AST_INIT_LATE: assert property (cyc_q >= 16'(T_INIT_CYC + 4) |->
        init_done) else $error("init never ended");
    AST_EN_INIT: assert property (!init_done |->
        converter_enable_out == '0) else $error("enable before init");
    AST_EN_VIN: assert property (
        (converter_enable_out & ~$past(converter_enable_out)) != '0 |->
        $past(input_voltage_sense, 3)) else $error("enable with input low");
    AST_REJ_CAUSE: assert property (wr_reject |-> $past(cmd_wr_stb) &&
        $past(cmd_wr.sel) == chonoff_pkg::CHO_CMD_POWER)
        else $error("reject without power write");
    AST_REJ_CTL: assert property (cmd_wr_stb && cmd_wr.data[7:6] == 2'b11 &&
        cmd_wr.sel == chonoff_pkg::CHO_CMD_POWER &&
        (cmd_wr.page < 8'h08 || cmd_wr.page == 8'hff) |=> wr_reject)
        else $error("control 11 not rejected");
    AST_MRG_CODE: assert property (!bad_mrg)
        else $error("margin select 11 seen");
    AST_IGN_NOM: assert property (!bad_ign)
        else $error("faults ignored at nominal");
endmodule : cho_checker
bind chonoff_top cho_checker #(.NUM_CHAN(NUM_CHAN), .T_INIT_CYC(T_INIT_CYC))
    u_chk (.ref_clk, .reset, .cmd_wr_stb, .cmd_wr, .cmd_rd_stb, .rd_data,
    .rd_valid, .wr_reject, .input_voltage_sense, .converter_enable_out,
    .margin_sel, .ignore_faults, .init_done);
`default_nettype wire

// [testbench/cho_host.sv]
// cho_host: host model that writes and reads the command bytes.
// assumes strobes are taken on the rising edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none
module cho_host (
    // clock
    input  wire logic             ref_clk,
    // writes
    output logic                  cmd_wr_stb,
    output chonoff_pkg::cho_wr_t  cmd_wr,
    // reads
    output logic                  cmd_rd_stb,
    output chonoff_pkg::cho_cmd_t cmd_rd_sel,
    output logic [7:0]            cmd_rd_page,
    input  wire logic [7:0]       rd_data,
    input  wire logic             rd_valid,
    input  wire logic             wr_reject
);
    initial begin
        cmd_wr_stb = 1'b0;
        cmd_wr = '0;
        cmd_rd_stb = 1'b0;
        cmd_rd_sel = chonoff_pkg::CHO_CMD_POWER;
        cmd_rd_page = 8'h00;
    end
    // released payload is scrambled so stale bytes never look valid
    task automatic wr(input logic [7:0] pg, input chonoff_pkg::cho_cmd_t sl,
                      input logic [7:0] dt, output logic rej);
        @(negedge ref_clk);
        cmd_wr = {pg, sl, dt};
        cmd_wr_stb = 1'b1;
        @(negedge ref_clk);
        cmd_wr_stb = 1'b0;
        cmd_wr = ~cmd_wr;
        rej = wr_reject;
    endtask : wr
    task automatic rd(input logic [7:0] pg, input chonoff_pkg::cho_cmd_t sl,
                      output logic [7:0] dt);
        @(negedge ref_clk);
        cmd_rd_page = pg;
        cmd_rd_sel = sl;
        cmd_rd_stb = 1'b1;
        @(negedge ref_clk);
        cmd_rd_stb = 1'b0;
        cmd_rd_page = ~pg;
        cmd_rd_sel = chonoff_pkg::cho_cmd_t'(~sl);
        dt = rd_valid ? rd_data : 8'hxx;
    endtask : rd
endmodule : cho_host
`default_nettype wire

// [testbench/chonoff_top_test.sv]
// chonoff_top_test: random and corner tests of the on/off control top.
// assumes cho_host and the bound checker are compiled with the design.
`timescale 1ns/10ps
`default_nettype none
module chonoff_top_test;
    localparam int NCH = 8;
    localparam int TINIT = 20;
    // off gap of our own choosing
    localparam int T_OFF_MIN = 40;
    localparam chonoff_pkg::cho_cmd_t PW = chonoff_pkg::CHO_CMD_POWER;
    localparam chonoff_pkg::cho_cmd_t SW = chonoff_pkg::CHO_CMD_SWITCH;
    logic                  ref_clk, reset, cmd_wr_stb, cmd_rd_stb, rej;
    logic                  rd_valid, wr_reject, share_clk, init_done;
    logic                  input_voltage_sense;
    chonoff_pkg::cho_wr_t  cmd_wr;
    chonoff_pkg::cho_cmd_t cmd_rd_sel;
    logic [7:0]            cmd_rd_page, rd_data, rv, d, p, cur;
    logic [NCH-1:0]        run_pin, converter_enable_out;
    logic [NCH-1:0]        ignore_faults, seq_off_busy;
    logic [NCH-1:0][15:0]  ton_delay, toff_delay;
    logic [NCH-1:0][1:0]   margin_sel;
    int                    bad_count, compares;
    chonoff_top #(.NUM_CHAN(NCH), .T_INIT_CYC(TINIT)) u_dut (
        .ref_clk, .reset, .cmd_wr_stb, .cmd_wr, .cmd_rd_stb, .cmd_rd_sel,
        .cmd_rd_page, .rd_data, .rd_valid, .wr_reject, .run_pin,
        .input_voltage_sense, .share_clk, .ton_delay, .toff_delay,
        .converter_enable_out, .margin_sel, .ignore_faults, .seq_off_busy,
        .init_done);
    cho_host u_host (.ref_clk, .cmd_wr_stb, .cmd_wr, .cmd_rd_stb, .cmd_rd_sel,
        .cmd_rd_page, .rd_data, .rd_valid, .wr_reject);
    always #5 ref_clk = ~ref_clk;
    always #83 share_clk = ~share_clk;
    function automatic logic [7:0] cfg_rb(input logic [7:0] v);
        return {3'b000, v[4:2], 1'b1, v[0]};
    endfunction : cfg_rb
    function automatic logic ok_op(input logic [7:0] v, input logic bus);
        if (v[7:6] == 2'b11) return 1'b0;
        if (bus && v[7:6] == 2'b00) return 1'b1;
        return v[5:4] == 2'b00 ||
               (v[5:4] != 2'b11 && (v[3:2] == 2'b01 || v[3:2] == 2'b10));
    endfunction : ok_op
    function automatic logic [1:0] mexp(input logic [7:0] v, input logic bus);
        return (bus && v[7:6] == 2'b00) ? 2'b00 : v[5:4];
    endfunction : mexp
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic settle(input logic [NCH-1:0] e);
        int n;
        n = 0;
        while (converter_enable_out !== e && n < 600) begin
            @(negedge ref_clk);
            n++;
        end
        chk("enable", e, converter_enable_out);
    endtask : settle
    task automatic gap();
        repeat (T_OFF_MIN) @(negedge ref_clk);
    endtask : gap
    task automatic conclude();
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    // about 3k cycles expected; gives up after 50k cycles
    initial begin
        #500000;
        bad_count++;
        conclude();
    end
    initial begin
        void'($urandom(32'h7c1fa25c));
        {ref_clk, share_clk, input_voltage_sense, run_pin} = '0;
        reset = 1'b1;
        bad_count = 0;
        compares = 0;
        cur = 8'h80;
        for (int i = 0; i < NCH; i++) begin
            ton_delay[i] = 16'($urandom_range(3, 0));
            toff_delay[i] = 16'($urandom_range(3, 2));
        end
        ton_delay[0] = 16'h0;
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            u_host.rd(8'(i), PW, rv);
            chk("op reset", 8'h80, rv);
            u_host.rd(8'(i), SW, rv);
            chk("cfg reset", 8'h1e, rv);
        end
        run_pin = '1;
        repeat (100) @(negedge ref_clk);
        chk("enable", 8'h00, converter_enable_out);
        chk("init", 8'h01, 8'(init_done));
        input_voltage_sense = 1'b1;
        settle('1);
        for (int i = 0; i < 12; i++) begin
            p = 8'($urandom_range(7, 0));
            d = 8'($urandom);
            u_host.wr(p, SW, d, rej);
            u_host.rd(p, SW, rv);
            chk("cfg", cfg_rb(d), rv);
        end
        run_pin = '0;
        u_host.wr(8'hff, SW, 8'h1e, rej);
        u_host.wr(8'h55, SW, 8'h00, rej);
        for (int i = 0; i < NCH; i++) begin
            u_host.rd(8'(i), SW, rv);
            chk("cfg global", 8'h1e, rv);
        end
        settle('0);
        for (int b = 0; b < 2; b++) begin
            u_host.wr(8'hff, SW, b[0] ? 8'h16 : 8'h1e, rej);
            for (int v = 0; v < 256; v++) begin
                d = 8'(v);
                u_host.wr(8'hff, PW, d, rej);
                chk("reject", 8'(!ok_op(d, !b[0])), 8'(rej));
                if (ok_op(d, !b[0])) cur = {d[7:2], 2'b00};
                p = 8'($urandom_range(7, 0));
                u_host.rd(p, PW, rv);
                chk("op", cur, rv);
                chk("margin", 8'(mexp(cur, !b[0])), 8'(margin_sel[p[2:0]]));
                chk("ignore", 8'(mexp(cur, !b[0]) != 2'b00 &&
                    cur[3:2] == 2'b01), 8'(ignore_faults[p[2:0]]));
            end
        end
        u_host.wr(8'h03, PW, 8'h00, rej);
        u_host.rd(8'h04, PW, rv);
        chk("op page", cur, rv);
        u_host.wr(8'hff, SW, 8'h1e, rej);
        u_host.wr(8'hff, PW, 8'h80, rej);
        gap();
        run_pin = '1;
        settle('1);
        run_pin = 8'($urandom);
        settle(run_pin);
        u_host.wr(8'hff, PW, 8'h00, rej);
        repeat (2) @(negedge ref_clk);
        chk("imm off", 8'h00, converter_enable_out);
        gap();
        u_host.wr(8'hff, SW, 8'h1a, rej);
        u_host.wr(8'hff, PW, 8'h80, rej);
        settle('1);
        u_host.wr(8'hff, PW, 8'h40, rej);
        repeat (3) @(negedge ref_clk);
        chk("seq busy", 8'hff, seq_off_busy);
        chk("seq hold", 8'hff, converter_enable_out);
        settle('0);
        gap();
        u_host.wr(8'hff, SW, 8'h15, rej);
        run_pin = '1;
        settle('1);
        run_pin = '0;
        repeat (7) @(negedge ref_clk);
        chk("fast off", 8'h00, converter_enable_out);
        chk("fast busy", 8'h00, seq_off_busy);
        gap();
        u_host.wr(8'hff, SW, 8'h10, rej);
        u_host.wr(8'hff, PW, 8'h80, rej);
        run_pin = '1;
        repeat (100) @(negedge ref_clk);
        chk("never on", 8'h00, converter_enable_out);
        run_pin = '0;
        u_host.wr(8'hff, PW, 8'h00, rej);
        u_host.wr(8'hff, SW, 8'h00, rej);
        settle('1);
        conclude();
    end
endmodule : chonoff_top_test
`default_nettype wire
